// file: hdl/adcsc_map.svh
// Register offsets, field positions, reset values and writable masks of the ADC sequencer configuration block.
// Included by the design; holds definitions only.
`ifndef ADCSC_MAP_SVH
`define ADCSC_MAP_SVH

// Byte offsets on the register bus
`define ADCSC_CTRL_OFS      8'h04
`define ADCSC_STATUS_OFS    8'h08
`define ADCSC_CLEAR_OFS     8'h0c
`define ADCSC_SEQUENCE_CONFIG_OFS    8'h14
`define ADCSC_DMACFG_OFS    8'h18
`define ADCSC_TIMING_OFS    8'h1c
`define ADCSC_TIMER_OFS     8'h20
`define ADCSC_WINCFG_OFS    8'h24
`define ADCSC_THRESH_OFS    8'h28
`define ADCSC_RESULT_OFS    8'h2c

// Reset values
`define ADCSC_SEQUENCE_CONFIG_RST    32'h0000_0000
`define ADCSC_TIMING_RST    32'h0000_0000
`define ADCSC_TIMER_RST     32'h0000_0000
`define ADCSC_WINCFG_RST    32'h0000_0000
`define ADCSC_THRESH_RST    32'h0000_0000

// Writable bit masks
`define ADCSC_SEQUENCE_CONFIG_MASK   32'h707f_d7f5
`define ADCSC_DMA_SEQ_MASK  32'h707f_d0f5
`define ADCSC_TIMING_MASK   32'h0000_011f
`define ADCSC_TIMER_MASK    32'h0000_ffff
`define ADCSC_WINCFG_MASK   32'h0000_7000
`define ADCSC_THRESH_MASK   32'h0fff_0fff

// Configuration field positions
`define ADCSC_MORE_BIT      31
`define ADCSC_SHIFT_HI      30
`define ADCSC_SHIFT_LO      28
`define ADCSC_NEG_HI        22
`define ADCSC_NEG_LO        20
`define ADCSC_POS_HI        19
`define ADCSC_POS_LO        16
`define ADCSC_NEGINT_BIT    15
`define ADCSC_POSINT_BIT    14
`define ADCSC_TRUN_BIT      13
`define ADCSC_RES_BIT       12
`define ADCSC_TRG_HI        10
`define ADCSC_TRG_LO        8
`define ADCSC_STUPEN_BIT    8
`define ADCSC_GAIN_ERROR_REDUCE_BIT     7
`define ADCSC_GAIN_HI       6
`define ADCSC_GAIN_LO       4
`define ADCSC_SOFT_TRIGGER_BIT     3
`define ADCSC_BIPOLAR_BIT   2
`define ADCSC_LADJ_BIT      0
`define ADCSC_STUP_HI       4
`define ADCSC_WM_HI         14
`define ADCSC_WM_LO         12
`define ADCSC_HT_HI         27
`define ADCSC_HT_LO         16
`define ADCSC_LT_HI         11

// Control register bits
`define ADCSC_CTRL_TRIG     0
`define ADCSC_CTRL_TSTART   1
`define ADCSC_CTRL_TSTOP    2

// Status register bits
`define ADCSC_ST_TTO        5
`define ADCSC_ST_MISS       3
`define ADCSC_ST_WIN        2
`define ADCSC_ST_SBUSY      26
`define ADCSC_ST_TBUSY      25

`endif

// file: hdl/adcsc_pkg.sv
// Types shared by the ADC sequencer configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
package adcsc_pkg;

  // Positive input source as routed to the converter
  typedef enum logic [2:0] {
    ADCSC_SRC_EXT    = 3'b000,
    ADCSC_SRC_BGAP   = 3'b001,
    ADCSC_SRC_VCC10  = 3'b010,
    ADCSC_SRC_DAC    = 3'b011,
    ADCSC_SRC_NONE   = 3'b100,
    ADCSC_SRC_VREF09 = 3'b110,
    ADCSC_SRC_REFGND = 3'b111
  } adcsc_src_t;

  // Trigger source selector codes
  typedef enum logic [2:0] {
    ADCSC_TRG_SOFT  = 3'b000,
    ADCSC_TRG_TIMER = 3'b001,
    ADCSC_TRG_INT   = 3'b010,
    ADCSC_TRG_CONT  = 3'b011,
    ADCSC_TRG_RISE  = 3'b100,
    ADCSC_TRG_FALL  = 3'b101,
    ADCSC_TRG_BOTH  = 3'b110,
    ADCSC_TRG_RSVD  = 3'b111
  } adcsc_trg_t;

  // Gain factor codes
  typedef enum logic [2:0] {
    ADCSC_GAIN_X1   = 3'b000,
    ADCSC_GAIN_X2   = 3'b001,
    ADCSC_GAIN_X4   = 3'b010,
    ADCSC_GAIN_X8   = 3'b011,
    ADCSC_GAIN_X16  = 3'b100,
    ADCSC_GAIN_X32  = 3'b101,
    ADCSC_GAIN_X64  = 3'b110,
    ADCSC_GAIN_HALF = 3'b111
  } adcsc_gain_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ADCSC_IDLE  = 2'b00,
    ADCSC_WAIT  = 2'b01,
    ADCSC_START = 2'b10,
    ADCSC_CONV  = 2'b11
  } adcsc_state_t;

  // Converter settings handed to the analog side
  typedef struct packed {
    adcsc_src_t  posSrc;       // Positive source kind
    logic [3:0]  posChannel;   // External channel when posSrc is EXT
    logic        posInternal;  // Positive side uses internal sources
    logic        negInternal;  // Negative side uses internal sources
    logic [2:0]  negSel;       // Negative selector
    logic [2:0]  shiftRef;     // Shift reference selector
    logic        res8;         // 8-bit conversions
    adcsc_gain_t gain;         // Gain factor
    logic        gainComp;     // Gain error reduction on
    logic        bipolar;      // Differential mode
    logic        leftAdjust;   // Left-adjusted result
  } adcsc_route_t;

endpackage

// file: hdl/adcsc_seq_config.sv
// ADC sequencer configuration: register file, DMA configuration port,
// trigger selection, start-up wait, internal timer and window monitor.
// Assumes one clock clk, an Avalon-MM master and a converter on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "adcsc_map.svh"

module adcsc_seq_config (
  // Clock, reset, enable
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // Avalon-MM slave
  input  wire logic [7:0]           avsAddress,
  input  wire logic                 avsRead,
  input  wire logic                 avsWrite,
  input  wire logic [31:0]          avsWritedata,
  input  wire logic [3:0]           avsByteenable,
  output logic      [31:0]          avsReaddata,
  output logic                      avsWaitrequest,
  // Trigger inputs
  input  wire logic                 extTriggerPin,
  input  wire logic                 intTrigger,
  // Converter side
  output adcsc_pkg::adcsc_route_t   route,
  output logic                      convStart,
  input  wire logic                 convDone,
  input  wire logic [11:0]          convRaw,
  // State seen by neighbours
  output logic      [15:0]          lastResult,
  output logic                      windowFlag,
  output logic                      timerTimeoutFlag,
  output logic                      seqBusy
);

  // Configuration registers
  logic [31:0] sequence_config_r;              // Sequence configuration
  logic [31:0] timing_r;              // Start-up timing
  logic [31:0] timerPeriod_r;         // Timer max count
  logic [31:0] winCfg_r;              // Window mode
  logic [31:0] thresh_r;              // High and low thresholds
  logic [31:0] dmaHold_r;             // First DMA word awaiting its second
  logic        dmaPending_r;          // Second DMA word expected
  logic [31:0] result_r;              // Last result with channels
  logic        missFlag_r;            // Trigger arrived while busy

  // Bus handshake
  logic        ack_r;                 // Second cycle of an access
  logic        req;                   // Access pending
  logic        wrStb;                 // Write takes effect now
  logic [31:0] wrMerged;              // Write data under byte enables

  // Timer
  logic        timerRun_r;            // Timer counting
  logic [15:0] timerCnt_r;            // Timer count
  logic        timerTick;             // One-cycle timeout

  // Triggers and sequencer
  logic        extSync1_r;            // Pin synchroniser, first stage
  logic        extSync2_r;            // Pin synchroniser, second stage
  logic        extPrev_r;             // Pin level one cycle earlier
  logic        softTrig;              // Software trigger request
  logic        trigEvent;             // Selected trigger fired
  adcsc_pkg::adcsc_state_t state_r;   // Sequencer state
  logic [4:0]  stupCnt_r;             // Start-up wait counter

  // Decoded DMA writes
  logic        dmaWr;                 // Write to the DMA port
  logic        dmaFirstApply;         // First word completes config
  logic        dmaSecondApply;        // Second word completes config
  logic [31:0] dmaFirst;              // First word being applied

  // Window monitor
  logic [11:0] cmpVal;                // Result at selected resolution
  logic        winHit;                // Window condition met

  // One wait state per access: request sampled, answered next cycle
  assign req            = avsRead | avsWrite;
  assign avsWaitrequest = req & ~(ack_r & ce);
  assign wrStb          = avsWrite & ack_r & ce;
  assign wrMerged       = {{8{avsByteenable[3]}}, {8{avsByteenable[2]}},
                           {8{avsByteenable[1]}}, {8{avsByteenable[0]}}} & avsWritedata;

  // Acknowledge toggles so back-to-back accesses each get a wait state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else if (ce) begin
      ack_r <= req & ~ack_r;
    end
  end

  // Read data captured in the wait cycle and held while acknowledged
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avsReaddata <= 32'h0000_0000;
    end else if (ce && avsRead && !ack_r) begin
      unique case (avsAddress)
        `ADCSC_STATUS_OFS: begin
          avsReaddata <= (32'(timerTimeoutFlag) << `ADCSC_ST_TTO)
                       | (32'(missFlag_r)       << `ADCSC_ST_MISS)
                       | (32'(windowFlag)       << `ADCSC_ST_WIN)
                       | (32'(seqBusy)          << `ADCSC_ST_SBUSY)
                       | (32'(timerRun_r)       << `ADCSC_ST_TBUSY);
        end
        `ADCSC_SEQUENCE_CONFIG_OFS: avsReaddata <= sequence_config_r;
        `ADCSC_TIMING_OFS: avsReaddata <= timing_r;
        `ADCSC_TIMER_OFS:  avsReaddata <= timerPeriod_r;
        `ADCSC_WINCFG_OFS: avsReaddata <= winCfg_r;
        `ADCSC_THRESH_OFS: avsReaddata <= thresh_r;
        `ADCSC_RESULT_OFS: avsReaddata <= result_r;
        // Write-only and unmapped offsets read as zero
        default:           avsReaddata <= 32'h0000_0000;
      endcase
    end
  end

  // DMA port decode; the writer keeps the second word's top bit clear
  assign dmaWr          = wrStb && (avsAddress == `ADCSC_DMACFG_OFS);
  assign dmaFirstApply  = dmaWr && !dmaPending_r && !wrMerged[`ADCSC_MORE_BIT];
  assign dmaSecondApply = dmaWr && dmaPending_r;
  assign dmaFirst       = dmaPending_r ? dmaHold_r : wrMerged;

  // Hold a first word whose continuation flag is set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dmaPending_r <= 1'b0;
      dmaHold_r    <= 32'h0000_0000;
    end else if (ce && dmaWr) begin
      if (dmaPending_r) begin
        dmaPending_r <= 1'b0;
      end else if (wrMerged[`ADCSC_MORE_BIT]) begin
        dmaPending_r <= 1'b1;
        dmaHold_r    <= wrMerged;
      end
    end
  end

  // Sequence configuration from bus or from the DMA first word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sequence_config_r <= `ADCSC_SEQUENCE_CONFIG_RST;
    end else if (ce) begin
      if (dmaFirstApply || dmaSecondApply) begin
        // Trigger selector is not in the DMA word and is kept
        sequence_config_r <= (sequence_config_r & ~`ADCSC_DMA_SEQ_MASK) | (dmaFirst & `ADCSC_DMA_SEQ_MASK);
      end else if (wrStb && avsAddress == `ADCSC_SEQUENCE_CONFIG_OFS) begin
        sequence_config_r <= wrMerged & `ADCSC_SEQUENCE_CONFIG_MASK;
      end
    end
  end

  // Start-up timing; the DMA word only carries the enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timing_r <= `ADCSC_TIMING_RST;
    end else if (ce) begin
      if (dmaFirstApply || dmaSecondApply) begin
        timing_r[`ADCSC_STUPEN_BIT] <= dmaFirst[`ADCSC_STUPEN_BIT];
      end else if (wrStb && avsAddress == `ADCSC_TIMING_OFS) begin
        timing_r <= wrMerged & `ADCSC_TIMING_MASK;
      end
    end
  end

  // Timer period and window settings
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timerPeriod_r <= `ADCSC_TIMER_RST;
      winCfg_r      <= `ADCSC_WINCFG_RST;
      thresh_r      <= `ADCSC_THRESH_RST;
    end else if (ce) begin
      if (wrStb && avsAddress == `ADCSC_TIMER_OFS) begin
        timerPeriod_r <= wrMerged & `ADCSC_TIMER_MASK;
      end
      if (dmaSecondApply) begin
        winCfg_r <= wrMerged & `ADCSC_WINCFG_MASK;
        thresh_r <= wrMerged & `ADCSC_THRESH_MASK;
      end else begin
        if (wrStb && avsAddress == `ADCSC_WINCFG_OFS) begin
          winCfg_r <= wrMerged & `ADCSC_WINCFG_MASK;
        end
        if (wrStb && avsAddress == `ADCSC_THRESH_OFS) begin
          thresh_r <= wrMerged & `ADCSC_THRESH_MASK;
        end
      end
    end
  end

  // Internal timer run control from DMA word or control register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timerRun_r <= 1'b0;
    end else if (ce) begin
      if (dmaFirstApply || dmaSecondApply) begin
        timerRun_r <= dmaFirst[`ADCSC_TRUN_BIT];
      end else if (wrStb && avsAddress == `ADCSC_CTRL_OFS) begin
        // Stop wins if both bits are written together
        if (wrMerged[`ADCSC_CTRL_TSTOP]) begin
          timerRun_r <= 1'b0;
        end else if (wrMerged[`ADCSC_CTRL_TSTART]) begin
          timerRun_r <= 1'b1;
        end
      end
    end
  end

  // Timer counts 0..max and wraps, one tick per max+1 cycles
  assign timerTick = timerRun_r && (timerCnt_r == timerPeriod_r[15:0]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timerCnt_r <= 16'h0000;
    end else if (ce) begin
      if (!timerRun_r || timerTick) begin
        timerCnt_r <= 16'h0000;
      end else begin
        timerCnt_r <= timerCnt_r + 16'h0001;
      end
    end
  end

  // Pin synchroniser; edges are taken from the second stage only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extSync1_r <= 1'b0;
      extSync2_r <= 1'b0;
      extPrev_r  <= 1'b0;
    end else if (ce) begin
      extSync1_r <= extTriggerPin;
      extSync2_r <= extSync1_r;
      extPrev_r  <= extSync2_r;
    end
  end

  // Software trigger from the DMA word or the control register
  assign softTrig = ((dmaFirstApply || dmaSecondApply) && dmaFirst[`ADCSC_SOFT_TRIGGER_BIT])
                 || (wrStb && avsAddress == `ADCSC_CTRL_OFS && wrMerged[`ADCSC_CTRL_TRIG]);

  // Trigger source selection
  always_comb begin
    trigEvent = 1'b0;
    unique case (adcsc_pkg::adcsc_trg_t'(sequence_config_r[`ADCSC_TRG_HI:`ADCSC_TRG_LO]))
      adcsc_pkg::ADCSC_TRG_SOFT:  trigEvent = softTrig;
      adcsc_pkg::ADCSC_TRG_TIMER: trigEvent = timerTick;
      adcsc_pkg::ADCSC_TRG_INT:   trigEvent = intTrigger;
      adcsc_pkg::ADCSC_TRG_CONT:  trigEvent = 1'b1;
      adcsc_pkg::ADCSC_TRG_RISE:  trigEvent = extSync2_r & ~extPrev_r;
      adcsc_pkg::ADCSC_TRG_FALL:  trigEvent = ~extSync2_r & extPrev_r;
      adcsc_pkg::ADCSC_TRG_BOTH:  trigEvent = extSync2_r ^ extPrev_r;
      adcsc_pkg::ADCSC_TRG_RSVD:  trigEvent = 1'b0;
    endcase
  end

  // Sequencer: optional start-up wait, start pulse, wait for result
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r   <= adcsc_pkg::ADCSC_IDLE;
      stupCnt_r <= 5'h00;
    end else if (ce) begin
      unique case (state_r)
        adcsc_pkg::ADCSC_IDLE: begin
          if (trigEvent) begin
            if ((dmaFirstApply || dmaSecondApply) ? dmaFirst[`ADCSC_STUPEN_BIT] : timing_r[`ADCSC_STUPEN_BIT]) begin
              state_r   <= adcsc_pkg::ADCSC_WAIT;
              stupCnt_r <= timing_r[`ADCSC_STUP_HI:0];
            end else begin
              state_r <= adcsc_pkg::ADCSC_START;
            end
          end
        end
        adcsc_pkg::ADCSC_WAIT: begin
          // Field value plus one cycles spent here before the start
          if (stupCnt_r == 5'h00) begin
            state_r <= adcsc_pkg::ADCSC_START;
          end else begin
            stupCnt_r <= stupCnt_r - 5'h01;
          end
        end
        adcsc_pkg::ADCSC_START: begin
          state_r <= adcsc_pkg::ADCSC_CONV;
        end
        adcsc_pkg::ADCSC_CONV: begin
          if (convDone) begin
            state_r <= adcsc_pkg::ADCSC_IDLE;
          end
        end
      endcase
    end
  end

  assign convStart = (state_r == adcsc_pkg::ADCSC_START);
  assign seqBusy   = (state_r != adcsc_pkg::ADCSC_IDLE);

  // Converter settings decoded from the sequence configuration
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      route <= '0;
    end else if (ce) begin
      route.posChannel  <= sequence_config_r[`ADCSC_POS_HI:`ADCSC_POS_LO];
      route.posInternal <= sequence_config_r[`ADCSC_POSINT_BIT];
      route.negInternal <= sequence_config_r[`ADCSC_NEGINT_BIT];
      route.negSel      <= sequence_config_r[`ADCSC_NEG_HI:`ADCSC_NEG_LO];
      route.shiftRef    <= sequence_config_r[`ADCSC_SHIFT_HI:`ADCSC_SHIFT_LO];
      route.res8        <= sequence_config_r[`ADCSC_RES_BIT];
      route.gain        <= adcsc_pkg::adcsc_gain_t'(sequence_config_r[`ADCSC_GAIN_HI:`ADCSC_GAIN_LO]);
      route.gainComp    <= sequence_config_r[`ADCSC_GAIN_ERROR_REDUCE_BIT];
      route.bipolar     <= sequence_config_r[`ADCSC_BIPOLAR_BIT];
      route.leftAdjust  <= sequence_config_r[`ADCSC_LADJ_BIT];
      if (!sequence_config_r[`ADCSC_POSINT_BIT]) begin
        // Top code routes the bandgap instead of a pad
        route.posSrc <= (sequence_config_r[`ADCSC_POS_HI:`ADCSC_POS_LO] == 4'hf)
                        ? adcsc_pkg::ADCSC_SRC_BGAP : adcsc_pkg::ADCSC_SRC_EXT;
      end else begin
        unique case (sequence_config_r[`ADCSC_POS_LO+2:`ADCSC_POS_LO])
          3'b001:  route.posSrc <= adcsc_pkg::ADCSC_SRC_BGAP;
          3'b010:  route.posSrc <= adcsc_pkg::ADCSC_SRC_VCC10;
          3'b011:  route.posSrc <= adcsc_pkg::ADCSC_SRC_DAC;
          3'b110:  route.posSrc <= adcsc_pkg::ADCSC_SRC_VREF09;
          3'b111:  route.posSrc <= adcsc_pkg::ADCSC_SRC_REFGND;
          // Unused codes connect nothing
          default: route.posSrc <= adcsc_pkg::ADCSC_SRC_NONE;
        endcase
      end
    end
  end

  // Window compare on the result at the selected resolution
  assign cmpVal = route.res8 ? {4'h0, convRaw[11:4]} : convRaw;

  always_comb begin
    winHit = 1'b0;
    unique case (winCfg_r[`ADCSC_WM_HI:`ADCSC_WM_LO])
      3'b000:  winHit = 1'b0;
      3'b001:  winHit = cmpVal > thresh_r[`ADCSC_LT_HI:0];
      3'b010:  winHit = cmpVal < thresh_r[`ADCSC_HT_HI:`ADCSC_HT_LO];
      3'b011:  winHit = (cmpVal > thresh_r[`ADCSC_LT_HI:0])
                     && (cmpVal < thresh_r[`ADCSC_HT_HI:`ADCSC_HT_LO]);
      3'b100:  winHit = (cmpVal <= thresh_r[`ADCSC_LT_HI:0])
                     || (cmpVal >= thresh_r[`ADCSC_HT_HI:`ADCSC_HT_LO]);
      // Reserved modes never flag
      default: winHit = 1'b0;
    endcase
  end

  // Last result formatted by resolution and alignment, with channels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_r <= 32'h0000_0000;
    end else if (ce && state_r == adcsc_pkg::ADCSC_CONV && convDone) begin
      result_r[22:20] <= route.negSel;
      result_r[19:16] <= route.posChannel;
      if (route.res8) begin
        result_r[15:0] <= route.leftAdjust ? {convRaw[11:4], 8'h00} : {8'h00, convRaw[11:4]};
      end else begin
        result_r[15:0] <= route.leftAdjust ? {convRaw, 4'h0} : {4'h0, convRaw};
      end
    end
  end

  assign lastResult = result_r[15:0];

  // Sticky flags; a new event beats a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      windowFlag       <= 1'b0;
      timerTimeoutFlag <= 1'b0;
      missFlag_r       <= 1'b0;
    end else if (ce) begin
      if (state_r == adcsc_pkg::ADCSC_CONV && convDone && winHit) begin
        windowFlag <= 1'b1;
      end else if (wrStb && avsAddress == `ADCSC_CLEAR_OFS && wrMerged[`ADCSC_ST_WIN]) begin
        windowFlag <= 1'b0;
      end
      if (timerTick) begin
        timerTimeoutFlag <= 1'b1;
      end else if (wrStb && avsAddress == `ADCSC_CLEAR_OFS && wrMerged[`ADCSC_ST_TTO]) begin
        timerTimeoutFlag <= 1'b0;
      end
      // Continuous mode is never counted as a miss
      if (trigEvent && seqBusy && sequence_config_r[`ADCSC_TRG_HI:`ADCSC_TRG_LO] != 3'b011) begin
        missFlag_r <= 1'b1;
      end else if (wrStb && avsAddress == `ADCSC_CLEAR_OFS && wrMerged[`ADCSC_ST_MISS]) begin
        missFlag_r <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// file: bench/adcsc_seq_config_checker.sv
// Port assertions for the sequencer configuration block.
// Bound to every instance of the block; one clock, reset active high.
`timescale 1ns/1ps
`default_nettype none
module adcsc_seq_config_checker (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    rst,
  // Watched ports
  input wire logic                    ce,
  input wire logic [7:0]              avsAddress,
  input wire logic                    avsRead,
  input wire logic                    avsWrite,
  input wire logic                    avsWaitrequest,
  input wire logic                    convStart,
  input wire logic                    convDone,
  input wire logic [11:0]             convRaw,
  input wire adcsc_pkg::adcsc_route_t route,
  input wire logic [15:0]             lastResult,
  input wire logic                    windowFlag,
  input wire logic                    timerTimeoutFlag,
  input wire logic                    seqBusy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Writes to the clear offset may drop sticky flags
  wire logic clrWr = avsWrite && (avsAddress == 8'h0c);
  idle_no_wait_a: assert property (!(avsRead || avsWrite) |-> !avsWaitrequest)
    else $error("waitrequest high without a request");
  start_pulse_a: assert property (convStart |=> !convStart)
    else $error("start pulse longer than one cycle");
  res_left_a: assert property (convDone && seqBusy && ce && route.res8 && route.leftAdjust
    |=> lastResult == {$past(convRaw[11:4]), 8'h00}) else $error("8-bit left result wrong");
  win_sticky_a: assert property (windowFlag && !clrWr |=> windowFlag)
    else $error("window flag dropped without clear");
  tmo_sticky_a: assert property (timerTimeoutFlag && !clrWr |=> timerTimeoutFlag)
    else $error("timeout flag dropped without clear");
  win_cause_a: assert property ($rose(windowFlag) |-> $past(convDone))
    else $error("window flag set with no result");
  res_cause_a: assert property (!$stable(lastResult) |-> $past(convDone))
    else $error("result changed with no conversion");
  res_right_a: assert property (convDone && seqBusy && ce && !route.res8 && !route.leftAdjust
    |=> lastResult == {4'h0, $past(convRaw)}) else $error("right adjusted result wrong");
endmodule
bind adcsc_seq_config adcsc_seq_config_checker u_chk (.clk, .rst, .ce, .avsAddress, .avsRead, .avsWrite,
  .avsWaitrequest, .convStart, .convDone, .convRaw, .route, .lastResult, .windowFlag, .timerTimeoutFlag, .seqBusy);
`default_nettype wire

// file: bench/adcsc_conv_model.sv
// Converter model: answers each start pulse with a done pulse and a sample.
// Shares clk with the block; the bench sets the sample before a start.
`timescale 1ns/1ps
`default_nettype none
module adcsc_conv_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Converter side
  input  wire logic        convStart,
  input  wire logic [11:0] sampleIn,
  output logic             convDone,
  output logic [11:0]      convRaw
);
  logic [1:0]  cnt_r;  // Cycles until done, zero when idle
  logic [11:0] keep_r; // Sample taken at start
  // Done follows start by three cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 2'h0;
      keep_r <= 12'h000;
    end else if (convStart) begin
      cnt_r <= 2'h3;
      keep_r <= sampleIn;
    end else if (cnt_r != 2'h0) begin
      cnt_r <= cnt_r - 2'h1;
    end
  end
  assign convDone = (cnt_r == 2'h1);
  // Inverse outside done, so a late sample shows up
  assign convRaw = convDone ? keep_r : ~keep_r;
endmodule
`default_nettype wire

// file: bench/adcsc_seq_config_tb_top.sv
// Bench for the sequencer configuration block: bus master, converter model, result model.
// Assumes the design, its map header and the converter model compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "adcsc_map.svh"
module adcsc_seq_config_tb_top;
  logic clk = 1'b0, rst = 1'b1, avsRead = 1'b0, avsWrite = 1'b0, avsWaitrequest, hit;
  logic convStart, convDone, seqBusy, windowFlag, timerTimeoutFlag;
  logic [7:0]  avsAddress = 8'h00;
  logic [11:0] sample = 12'h000, convRaw, v, lt, ht;
  logic [15:0] lastResult, expRes;
  logic [31:0] avsWritedata = 32'h0, avsReaddata, rd, w1, w2, prev;
  logic [7:0]  regA [7] = '{8'h14, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h3c, 8'h18};
  logic [31:0] regM [7] = '{`ADCSC_SEQUENCE_CONFIG_MASK, `ADCSC_TIMING_MASK, `ADCSC_TIMER_MASK, `ADCSC_WINCFG_MASK,
                            `ADCSC_THRESH_MASK, 32'h0, 32'h0};
  adcsc_pkg::adcsc_route_t route;
  integer n_errors = 0, checks_done = 0, seed = 36, i, n;
  realtime t0;
  always #20 clk = ~clk;
  adcsc_seq_config dut (.clk, .rst, .ce(1'b1), .avsAddress, .avsRead, .avsWrite, .avsWritedata,
    .avsByteenable(4'hf), .avsReaddata, .avsWaitrequest, .extTriggerPin(1'b0), .intTrigger(1'b0),
    .route, .convStart, .convDone, .convRaw, .lastResult, .windowFlag, .timerTimeoutFlag, .seqBusy);
  adcsc_conv_model conv (.clk, .rst, .convStart, .sampleIn(sample), .convDone, .convRaw);
  // One bus access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    do @(posedge clk); while (avsWaitrequest !== 1'b0);
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Expected positive source kind of a configuration word
  function automatic logic [2:0] srcExp(input logic [31:0] w);
    if (!w[14]) return (w[19:16] == 4'hf) ? 3'h1 : 3'h0;
    return (w[18:16] inside {3'h0, 3'h4, 3'h5}) ? 3'h4 : w[18:16];
  endfunction
  // Watchdog, far beyond the run's length
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    finish_test;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // Reset values, masks, unmapped and write-only places
    for (i = 0; i < 7; i++) begin
      bus(1'b0, regA[i], 32'h0);
      chk(rd, 32'h0);
      if (i < 6) bus(1'b1, regA[i], 32'hffff_ffff);
      bus(1'b0, regA[i], 32'h0);
      chk(rd, regM[i]);
    end
    // Every selector and gain code; trigger kept reserved so nothing starts
    for (i = 0; i < 32; i++) begin
      w1 = ($random(seed) & 32'h7070_b7b5) | (i[3:0] << 16) | (i[4] << 14) | (i[2:0] << 4) | 32'h700;
      bus(1'b1, 8'h14, w1);
      repeat (2) @(posedge clk);
      chk({route.posSrc, route.posInternal, route.negInternal, route.res8, route.gain, route.gainComp, route.bipolar,
           route.leftAdjust, route.posChannel, route.negSel, route.shiftRef}, {srcExp(w1), w1[14], w1[15], w1[12],
           w1[6:4], w1[7], w1[2], w1[0], w1[19:16], w1[22:20], w1[30:28]});
    end
    bus(1'b1, 8'h04, 32'h1);
    repeat (8) @(posedge clk);
    chk(seqBusy, 1'b0);
    bus(1'b1, 8'h14, 32'h0);
    bus(1'b1, 8'h1c, 32'h3);
    prev = 32'h0;
    // Two-word DMA setup, soft start, start-up wait, result, window
    for (i = 0; i < 8; i++) begin
      lt = $random(seed);
      ht = $random(seed);
      sample = $random(seed);
      w1 = 32'h8000_0008 | (i[0] << 12) | i[1] | (i[2] << 8) | ($random(seed) & 32'h707f_c0f4);
      w2 = {4'h0, ht, 1'b0, i[2:0], lt};
      bus(1'b1, 8'h0c, 32'h24);
      bus(1'b1, 8'h18, w1);
      bus(1'b0, 8'h14, 32'h0);
      chk(rd, prev);
      bus(1'b1, 8'h18, w2);
      n = 0;
      do begin @(posedge clk); n++; end while (convStart !== 1'b1);
      chk(n, i[2] ? 5 : 1);
      while (seqBusy !== 1'b0) @(posedge clk);
      v = i[0] ? {4'h0, sample[11:4]} : sample;
      expRes = i[0] ? (i[1] ? {sample[11:4], 8'h00} : {8'h00, sample[11:4]}) : (i[1] ? {sample, 4'h0} : {4'h0, sample});
      chk(lastResult, expRes);
      case (i[2:0])
        3'h1: hit = v > lt;
        3'h2: hit = v < ht;
        3'h3: hit = v > lt && v < ht;
        3'h4: hit = v <= lt || v >= ht;
        default: hit = 1'b0;
      endcase
      chk(windowFlag, hit);
      prev = w1 & `ADCSC_DMA_SEQ_MASK;
      bus(1'b0, 8'h14, 32'h0);
      chk(rd, prev);
      bus(1'b0, 8'h28, 32'h0);
      chk(rd, w2 & `ADCSC_THRESH_MASK);
    end
    // Timer started by the DMA run bit, period from max count plus one
    bus(1'b1, 8'h20, 32'h9);
    bus(1'b1, 8'h18, 32'h2000);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd[25], 1'b1);
    @(posedge timerTimeoutFlag);
    t0 = $realtime;
    bus(1'b1, 8'h0c, 32'h20);
    @(posedge timerTimeoutFlag);
    chk(int'(($realtime - t0) / 40.0), 10);
    bus(1'b1, 8'h18, 32'h0);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd[25], 1'b0);
    finish_test;
  end
endmodule
`default_nettype wire
